/* File: dv/dmh_dev_model.sv */
// Behavioural model of the DMA device, channel 0 only, byte units
`timescale 1ns/1ns
module dmh_dev_model (
   // Clock and reset
   input  wire logic        CLOCK,
   input  wire logic        RESET_N,
   // Register port
   input  wire logic        DEV_PSEL,
   input  wire logic        DEV_PENABLE,
   input  wire logic        DEV_PWRITE,
   input  wire logic [31:0] DEV_PADDR,
   input  wire logic [31:0] DEV_PWDATA,
   input  wire logic        DEV_PSIZE,
   output logic             DEV_PREADY,
   output logic [31:0]      DEV_PRDATA,
   // Request pin and NMI
   input  wire logic        REQ_PIN,
   input  wire logic        NMI
);
   logic [31:0] rg [64];
   logic [31:0] sar0, junk, n;
   logic        req_q, fire, wr, irq;
   // Released data bus shows a moving pattern, not the last value
   assign DEV_PRDATA = DEV_PREADY ? rg[DEV_PADDR[7:2]] : junk;
   assign wr = DEV_PSEL && DEV_PENABLE && DEV_PREADY && DEV_PWRITE;
   assign fire = req_q && !REQ_PIN && rg[3][0] && rg[44][0] && !rg[44][1];
   // end interrupt needs count zero and enable
   assign irq = rg[3][1] && rg[3][2];
   // halt after four with reload; each request starts a fresh group
   assign n = rg[3][16] ? 32'h4 : rg[2];
   always_ff @(posedge CLOCK or negedge RESET_N) begin
      if (!RESET_N) begin
         foreach (rg[i]) rg[i] <= '0;
         DEV_PREADY <= 0;
         req_q <= 1;
         junk <= 32'h5A3C_96E1;
      end else begin
         junk <= ~junk;
         // each falling edge is one fresh request
         req_q <= REQ_PIN;
         DEV_PREADY <= DEV_PSEL && DEV_PENABLE && !DEV_PREADY && ($urandom % 3 == 0);
         if (wr && !(DEV_PADDR[7:2] == 6'd44 && DEV_PSIZE)) rg[DEV_PADDR[7:2]] <= DEV_PWDATA;
         if (wr && DEV_PADDR[7:2] == 6'd0) sar0 <= DEV_PWDATA;
         if (fire) begin
            // longword pointer read per unit when indirect
            rg[0] <= rg[3][16] ? sar0 : rg[0] + (rg[3][6] ? n << 2 : n);
            rg[1] <= rg[1] + n;
            rg[2] <= rg[2] - n;
            if (rg[2] == n) rg[3][1] <= 1;
         end
         if (NMI) rg[44][1] <= 1;
      end
   end
endmodule // dmh_dev_model

/* File: dv/dmh_host_asserts.sv */
// Port-level checks for the DMA host controller
`timescale 1ns/1ns
module dmh_host_asserts #(
   parameter logic [31:0] DEV_BASE = 32'h0000_8600
) (
   // Clock, reset and software port
   input  wire logic        CLOCK,
   input  wire logic        RESET_N,
   input  wire logic        PSEL,
   input  wire logic        PENABLE,
   input  wire logic        PREADY,
   // Device port and request pin
   input  wire logic        DEV_PSEL,
   input  wire logic        DEV_PENABLE,
   input  wire logic        DEV_PWRITE,
   input  wire logic [31:0] DEV_PADDR,
   input  wire logic [31:0] DEV_PWDATA,
   input  wire logic        DEV_PSIZE,
   input  wire logic        DEV_PREADY,
   input  wire logic        REQ_PIN
);
   default clocking @(posedge CLOCK); endclocking
   default disable iff (!RESET_N);
   property p_op_word;
      DEV_PSEL && DEV_PADDR == DEV_BASE + 32'hB0 |-> !DEV_PSIZE;
   endproperty
   a_op_word: assert property (p_op_word) else $error("operation register not word sized");
   property p_hole;
      DEV_PSEL |-> !(DEV_PADDR >= DEV_BASE + 32'hB2 && DEV_PADDR <= DEV_BASE + 32'hBF);
   endproperty
   a_hole: assert property (p_hole) else $error("unused device address touched");
   property p_trig;
      $fell(REQ_PIN) |=> !REQ_PIN ##1 REQ_PIN;
   endproperty
   a_trig: assert property (p_trig) else $error("request pulse not two cycles");
   // Address and count writes only while the pin rests high
   property p_quiet;
      !REQ_PIN |-> !(DEV_PSEL && DEV_PWRITE && DEV_PADDR[3:2] != 2'b11 && DEV_PADDR[7:4] != 4'hB);
   endproperty
   a_quiet: assert property (p_quiet) else $error("programming while request low");
   property p_hold;
      DEV_PSEL && !DEV_PREADY |=> $stable(DEV_PADDR) && $stable(DEV_PWDATA) && $stable(DEV_PSIZE);
   endproperty
   a_hold: assert property (p_hold) else $error("device request changed before ready");
   property p_access;
      DEV_PSEL && !DEV_PENABLE |=> DEV_PSEL && DEV_PENABLE;
   endproperty
   a_access: assert property (p_access) else $error("device setup not followed by access");
   property p_release;
      DEV_PSEL && DEV_PENABLE && DEV_PREADY |=> !DEV_PSEL;
   endproperty
   a_release: assert property (p_release) else $error("device select kept after ready");
   property p_ready;
      PSEL && !PENABLE |=> PREADY;
   endproperty
   a_ready: assert property (p_ready) else $error("software port did not answer");
endmodule // dmh_host_asserts
bind dmh_host dmh_host_asserts #(.DEV_BASE(DEV_BASE)) u_chk (.*);

/* File: dv/dmh_host_tb.sv */
// Self-checking bench for the DMA host controller
`timescale 1ns/1ns
`include "dmh_regs.svh"
module dmh_host_tb;
   logic        CLOCK = 0, RESET_N = 0, PSEL = 0, PENABLE = 0, PWRITE = 0, NMI = 0;
   logic [7:0]  PADDR = 0;
   logic [31:0] PWDATA = 0, PRDATA, DEV_PADDR, DEV_PWDATA, DEV_PRDATA, rd, s, d, v, m, e;
   logic        PREADY, PSLVERR, DEV_PSEL, DEV_PENABLE, DEV_PWRITE, DEV_PSIZE, DEV_PREADY, REQ_PIN, er;
   int          fails = 0, check_count = 0, nacc = 0, arms = 0, n0, n1, na;
   logic [64:0] q[$];
   logic [31:0] rc[4] = '{32'h10, 32'h30, 32'h0, 32'h100};
   logic [31:0] rs[4] = '{32'h100, 32'h100, 32'h8640, 32'hFFFF_1000};
   logic [31:0] rn[4] = '{8, 6, 8, 8};
   always #5 CLOCK = ~CLOCK;
   dmh_host dut (.*);
   dmh_dev_model u_dev (.*);
   task chk(input string nm, input [31:0] ex, gt);
      check_count++;
      if (gt !== ex) begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", nm, ex, gt);
      end
   endtask
   task apb(input w, input [7:0] a, input [31:0] dt, mk, ex, input xe = 0);
      q.push_back({mk, ex, xe});
      @(posedge CLOCK);
      PSEL <= 1;
      PWRITE <= w;
      PADDR <= a;
      PWDATA <= dt;
      @(posedge CLOCK);
      PENABLE <= 1;
      n1 = 0;
      do @(posedge CLOCK); while (!PREADY && ++n1 < 50);
      if (n1 >= 50) fails++;
      rd = PRDATA;
      PSEL <= 0;
      PENABLE <= 0;
   endtask
   task poll(input [31:0] mk, vl);
      apb(0, `DMH_A_STATUS, 0, 0, 0);
      repeat (200) if ((rd & mk) !== vl) apb(0, `DMH_A_STATUS, 0, 0, 0);
      chk("status", vl, rd & mk);
   endtask
   task go(input [31:0] c, sa, cnt);
      n0 = arms;
      apb(1, `DMH_A_SRC, sa, 0, 0);
      apb(1, `DMH_A_DST, d, 0, 0);
      apb(1, `DMH_A_COUNT, cnt, 0, 0);
      apb(1, `DMH_A_CTRL, c | 1, 0, 0);
   endtask
   task arm;
      repeat (400) if (arms == n0) @(posedge CLOCK);
      if (arms == n0) fails++;
   endtask
   task close_out;
      $display("checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   // Result watcher pairs each answer with the oldest expectation
   always @(posedge CLOCK) begin
      if (PSEL && PENABLE && PREADY) begin
         {m, e, er} = q.pop_front();
         chk("prdata", e, PRDATA & m);
         chk("pslverr", {31'h0, er}, {31'h0, PSLVERR});
      end
      nacc += DEV_PSEL && !DEV_PENABLE;
      arms += DEV_PSEL && DEV_PENABLE && DEV_PREADY && DEV_PWRITE && DEV_PADDR[7:0] == 8'h0C && DEV_PWDATA[0];
   end
   initial begin
      #900_000;
      fails++;
      close_out;
   end
   initial begin
      void'($urandom(32'h89a156e3));
      repeat (8) @(posedge CLOCK);
      RESET_N <= 1;
      v = $urandom & `DMH_CTRL_MASK;
      apb(1, `DMH_A_CTRL, v, 0, 0);
      apb(0, `DMH_A_CTRL, 0, '1, v);
      apb(0, 8'h14, 0, '1, 0, 1);
      d = 32'h0001_0000 | ($urandom & 32'hFFC);
      s = $urandom & 32'h7FFC;
      go(32'h70, s, 8);
      arm;
      apb(1, `DMH_A_CTRL, 32'h78, 0, 0);
      repeat (300) if (u_dev.rg[2] !== 4) @(posedge CLOCK);
      chk("count", 4, u_dev.rg[2]);
      chk("source", s, u_dev.rg[0]);
      chk("dest", d + 4, u_dev.rg[1]);
      chk("end irq", 0, {31'h0, u_dev.irq});
      apb(1, `DMH_A_CTRL, 32'h78, 0, 0);
      poll(32'h3, 32'h2);
      chk("end irq", 1, {31'h0, u_dev.irq});
      go(32'hA0, s, 8);
      arm;
      apb(1, `DMH_A_CTRL, 32'hA8, 0, 0);
      poll(32'h3, 32'h2);
      chk("source", s + 32, u_dev.rg[0]);
      chk("dest", d + 8, u_dev.rg[1]);
      chk("count", 0, u_dev.rg[2]);
      chk("end irq", 0, {31'h0, u_dev.irq});
      for (int i = 0; i < 4; i++) begin
         na = nacc;
         go(rc[i], rs[i], rn[i]);
         poll(32'h5, 32'h4);
         chk("device accesses", na, nacc);
      end
      go(32'h30, s, 8);
      arm;
      @(posedge CLOCK) NMI <= 1;
      @(posedge CLOCK) NMI <= 0;
      poll(32'h11, 32'h10);
      apb(1, `DMH_A_CTRL, 32'h34, 0, 0);
      poll(32'h10, 32'h0);
      chk("nmi flag", 0, u_dev.rg[44][1]);
      go(32'h30, s, 8);
      arm;
      apb(1, `DMH_A_CTRL, 32'h32, 0, 0);
      poll(32'h9, 32'h8);
      chk("operation", 0, u_dev.rg[44]);
      chk("enable", 0, u_dev.rg[3][0]);
      close_out;
   end
endmodule // dmh_host_tb

/* File: hw/dmh_apb_regs.sv */
// APB slave holding the software command and configuration registers
`timescale 1ns/1ns
`include "dmh_regs.svh"
module dmh_apb_regs (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        reset_n,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // To the sequencer
   output logic [31:0]      ctrl,
   output logic [31:0]      src,
   output logic [31:0]      dst,
   output logic [31:0]      count,
   output logic [3:0]       pulses,
   input  wire logic [31:0] status
);
   logic setup;
   logic wr;

   assign setup = psel && !penable;
   assign wr    = psel && penable && pready && pwrite;

   function automatic logic mapped(input logic [7:0] a);
      mapped = (a == `DMH_A_CTRL) || (a == `DMH_A_SRC) || (a == `DMH_A_DST) ||
               (a == `DMH_A_COUNT) || (a == `DMH_A_STATUS);
   endfunction

   // Every access answers in its first access cycle
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end else begin
         pready  <= setup;
         pslverr <= setup && !mapped(paddr);
         case (paddr)
            `DMH_A_CTRL:   prdata <= ctrl;
            `DMH_A_SRC:    prdata <= src;
            `DMH_A_DST:    prdata <= dst;
            `DMH_A_COUNT:  prdata <= count;
            `DMH_A_STATUS: prdata <= status;
            default:       prdata <= 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         ctrl   <= 32'h0000_0000;
         src    <= 32'h0000_0000;
         dst    <= 32'h0000_0000;
         count  <= 32'h0000_0000;
         pulses <= 4'h0;
      end else begin
         pulses <= 4'h0;
         if (wr) begin
            case (paddr)
               `DMH_A_CTRL: begin
                  ctrl   <= pwdata & `DMH_CTRL_MASK;
                  pulses <= pwdata[3:0];
               end
               `DMH_A_SRC:   src <= pwdata;
               `DMH_A_DST:   dst <= pwdata;
               `DMH_A_COUNT: count <= pwdata;
               default: ;
            endcase
         end
      end
   end
endmodule // dmh_apb_regs

/* File: hw/dmh_dev_master.sv */
// Bus master that performs one register access on the device interface
`timescale 1ns/1ns
`include "dmh_regs.svh"
module dmh_dev_master (
   // Clock and reset
   input  wire logic              clk,
   input  wire logic              reset_n,
   // Command from the sequencer
   input  wire logic              cmd_valid,
   input  wire logic              cmd_write,
   input  wire logic [31:0]       cmd_addr,
   input  wire logic [31:0]       cmd_wdata,
   input  dmh_pkg::dmh_size_t     cmd_size,
   output logic                   cmd_done,
   output logic [31:0]            cmd_rdata,
   // Device pins
   output logic                   psel,
   output logic                   penable,
   output logic                   pwrite,
   output logic [31:0]            paddr,
   output logic [31:0]            pwdata,
   output logic                   psize,
   input  wire logic              pready,
   input  wire logic [31:0]       prdata
);
   import dmh_pkg::*;

   // Request held stable from setup until pready is seen
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         psel    <= 1'b0;
         penable <= 1'b0;
         pwrite  <= 1'b0;
         paddr   <= 32'h0000_0000;
         pwdata  <= 32'h0000_0000;
         psize   <= 1'b0;
      end else if (!psel && cmd_valid) begin
         psel    <= 1'b1;
         pwrite  <= cmd_write;
         paddr   <= cmd_addr;
         pwdata  <= cmd_wdata;
         psize   <= (cmd_size == DMH_LONG);
      end else if (psel && !penable) begin
         penable <= 1'b1;
      end else if (psel && pready) begin
         psel    <= 1'b0;
         penable <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         cmd_done  <= 1'b0;
         cmd_rdata <= 32'h0000_0000;
      end else begin
         cmd_done <= psel && penable && pready;
         if (psel && penable && pready && !pwrite)
            cmd_rdata <= prdata;
      end
   end
endmodule // dmh_dev_master

/* File: hw/dmh_host.sv */
// DMA host controller: programs and watches one channel of the DMA device
`timescale 1ns/1ns
`include "dmh_regs.svh"
module dmh_host #(
   parameter logic [31:0] DEV_BASE  = 32'h0000_8600,
   parameter logic [31:0] INT_BASE  = 32'hFFFF_0000,
   parameter logic [31:0] PROT_LO   = 32'hFFFF_8000,
   parameter logic [31:0] PROT_HI   = 32'hFFFF_80FF
) (
   // Clock and reset
   input  wire logic              CLOCK,
   input  wire logic              RESET_N,
   // Software APB port
   input  wire logic              PSEL,
   input  wire logic              PENABLE,
   input  wire logic              PWRITE,
   input  wire logic [7:0]        PADDR,
   input  wire logic [31:0]       PWDATA,
   output logic [31:0]            PRDATA,
   output logic                   PREADY,
   output logic                   PSLVERR,
   // Device register port
   output logic                   DEV_PSEL,
   output logic                   DEV_PENABLE,
   output logic                   DEV_PWRITE,
   output logic [31:0]            DEV_PADDR,
   output logic [31:0]            DEV_PWDATA,
   output logic                   DEV_PSIZE,
   input  wire logic              DEV_PREADY,
   input  wire logic [31:0]       DEV_PRDATA,
   // External request pin, falling edge active
   output logic                   REQ_PIN
);
   import dmh_pkg::*;

   logic [31:0]     ctrl;
   logic [31:0]     src;
   logic [31:0]     dst;
   logic [31:0]     count;
   logic [3:0]      pulses;
   logic [31:0]     status;
   dmh_state_t      state;
   logic            waiting;
   logic            issue;
   logic            cmd_write;
   logic [31:0]     cmd_addr;
   logic [31:0]     cmd_wdata;
   dmh_size_t       cmd_size;
   logic            cmd_done;
   logic [31:0]     cmd_rdata;
   logic            done;
   logic            refused;
   logic            stby_ok;
   logic            nmi_seen;
   logic            ae_seen;
   logic            stby_pend;
   logic            nmi_pend;
   logic            trig_pend;
   logic [3:0]      trig_cnt;
   logic            programming;
   logic [1:0]      chan;

   dmh_apb_regs u_regs (
      .clk     (CLOCK),
      .reset_n (RESET_N),
      .psel    (PSEL),
      .penable (PENABLE),
      .pwrite  (PWRITE),
      .paddr   (PADDR),
      .pwdata  (PWDATA),
      .prdata  (PRDATA),
      .pready  (PREADY),
      .pslverr (PSLVERR),
      .ctrl    (ctrl),
      .src     (src),
      .dst     (dst),
      .count   (count),
      .pulses  (pulses),
      .status  (status)
   );

   dmh_dev_master u_master (
      .clk       (CLOCK),
      .reset_n   (RESET_N),
      .cmd_valid (issue),
      .cmd_write (cmd_write),
      .cmd_addr  (cmd_addr),
      .cmd_wdata (cmd_wdata),
      .cmd_size  (cmd_size),
      .cmd_done  (cmd_done),
      .cmd_rdata (cmd_rdata),
      .psel      (DEV_PSEL),
      .penable   (DEV_PENABLE),
      .pwrite    (DEV_PWRITE),
      .paddr     (DEV_PADDR),
      .pwdata    (DEV_PWDATA),
      .psize     (DEV_PSIZE),
      .pready    (DEV_PREADY),
      .prdata    (DEV_PRDATA)
   );

   assign chan        = ctrl[`DMH_C_CH_LO +: 2];
   assign programming = (state != S_IDLE) && (state != S_MON_CH) && (state != S_MON_OR);
   assign status      = {22'h00_0000, 4'(state), ae_seen, nmi_seen, stby_ok,
                         refused, done, (state != S_IDLE)};

   function automatic logic [31:0] chan_addr(input logic [1:0] ch, input logic [31:0] off);
      chan_addr = DEV_BASE + (32'(ch) * `DMH_D_STRIDE) + off;
   endfunction

   function automatic logic in_hole(input logic [31:0] a);
      in_hole = (a >= DEV_BASE + `DMH_D_HOLE_LO) && (a <= DEV_BASE + `DMH_D_HOLE_HI);
   endfunction

   function automatic logic forbidden(input logic [31:0] a);
      forbidden = ((a >= DEV_BASE) && (a < DEV_BASE + `DMH_D_SPAN)) ||
                  ((a >= PROT_LO) && (a <= PROT_HI)) || in_hole(a);
   endfunction

   // Channel control image; reload and indirect bits carried into the device
   function automatic logic [31:0] channel_control_reg_img(input logic [31:0] c, input logic de);
      logic [31:0] v;
      v = 32'h0000_0000;
      v[`DMH_B_DE]                 = de;
      v[`DMH_B_IE]                 = c[`DMH_C_IRQEN];
      v[`DMH_B_TS_LO +: 2]         = c[`DMH_C_TS_LO +: 2];
      v[`DMH_B_BURST]              = c[`DMH_C_BURST];
      v[`DMH_B_INDIR]              = c[`DMH_C_INDIR];
      v[`DMH_B_SINGLE]             = c[`DMH_C_SINGLE];
      v[`DMH_B_RS_LO +: 4]         = c[`DMH_C_RS_LO +: 4];
      v[`DMH_B_SM_LO +: 2]         = c[`DMH_C_SM_LO +: 2];
      v[`DMH_B_DM_LO +: 2]         = c[`DMH_C_DM_LO +: 2];
      v[`DMH_B_RELOAD]             = c[`DMH_C_RELOAD];
      channel_control_reg_img = v;
   endfunction

   // Start a device access on first entry, then wait for the answer
   task automatic access(input logic wr, input logic [31:0] a, input logic [31:0] d, input dmh_size_t sz);
      if (!waiting) begin
         issue     <= 1'b1;
         waiting   <= 1'b1;
         cmd_write <= wr;
         cmd_addr  <= a;
         cmd_wdata <= d;
         cmd_size  <= sz;
      end
   endtask

   always_ff @(posedge CLOCK or negedge RESET_N) begin
      if (!RESET_N) begin
         state     <= S_IDLE;
         waiting   <= 1'b0;
         issue     <= 1'b0;
         cmd_write <= 1'b0;
         cmd_addr  <= 32'h0000_0000;
         cmd_wdata <= 32'h0000_0000;
         cmd_size  <= DMH_LONG;
      end else begin
         issue <= 1'b0;
         if (cmd_done)
            waiting <= 1'b0;
         case (state)
            S_IDLE: begin
               if (stby_pend)
                  state <= S_STBY_OR;
               else if (nmi_pend)
                  state <= S_NMI_OR;
               else if (pulses[`DMH_C_GO])
                  state <= S_CHECK;
            end
            S_CHECK: begin
               if (ctrl[`DMH_C_RELOAD] && !ctrl[`DMH_C_BURST])
                  state <= S_IDLE;
               else if (ctrl[`DMH_C_RELOAD] && (count[1:0] != 2'b00))
                  state <= S_IDLE;
               else if (ctrl[`DMH_C_SINGLE] && (src >= INT_BASE))
                  state <= S_IDLE;
               else if (forbidden(src) || forbidden(dst))
                  state <= S_IDLE;
               else
                  state <= S_RD_CHANNEL_CONTROL_REG;
            end
            S_RD_CHANNEL_CONTROL_REG: begin
               access(1'b0, chan_addr(chan, `DMH_D_CHANNEL_CONTROL_REG), 32'h0000_0000, DMH_LONG);
               if (cmd_done)
                  state <= S_CLR_DE;
            end
            S_CLR_DE: begin
               // enable cleared before new request select
               access(1'b1, chan_addr(chan, `DMH_D_CHANNEL_CONTROL_REG),
                      cmd_rdata & ~(32'h0000_0001 << `DMH_B_DE), DMH_LONG);
               if (cmd_done && waiting)
                  state <= S_WR_TCR0;
            end
            S_WR_TCR0: begin
               access(1'b1, chan_addr(chan, `DMH_D_TCR), 32'h0000_0000, DMH_LONG);
               if (cmd_done && waiting)
                  state <= S_WR_SAR;
            end
            S_WR_SAR: begin
               access(1'b1, chan_addr(chan, `DMH_D_SAR), src, DMH_LONG);
               if (cmd_done && waiting)
                  state <= S_WR_DAR;
            end
            S_WR_DAR: begin
               access(1'b1, chan_addr(chan, `DMH_D_DAR), dst, DMH_LONG);
               if (cmd_done && waiting)
                  state <= S_WR_TCR;
            end
            S_WR_TCR: begin
               access(1'b1, chan_addr(chan, `DMH_D_TCR), count, DMH_LONG);
               if (cmd_done && waiting)
                  state <= S_WR_OR_ON;
            end
            S_WR_OR_ON: begin
               access(1'b1, DEV_BASE + `DMH_D_OPREG, 32'h0000_0001 << `DMH_O_DME, DMH_WORD);
               if (cmd_done && waiting)
                  state <= S_WR_CHANNEL_CONTROL_REG;
            end
            S_WR_CHANNEL_CONTROL_REG: begin
               // control written as the final step
               access(1'b1, chan_addr(chan, `DMH_D_CHANNEL_CONTROL_REG), channel_control_reg_img(ctrl, 1'b1), DMH_LONG);
               if (cmd_done && waiting)
                  state <= S_MON_CH;
            end
            S_MON_CH: begin
               access(1'b0, chan_addr(chan, `DMH_D_CHANNEL_CONTROL_REG), 32'h0000_0000, DMH_LONG);
               if (cmd_done && waiting)
                  state <= cmd_rdata[`DMH_B_TE] ? S_IDLE : S_MON_OR;
            end
            S_MON_OR: begin
               access(1'b0, DEV_BASE + `DMH_D_OPREG, 32'h0000_0000, DMH_WORD);
               if (cmd_done && waiting) begin
                  if (stby_pend)
                     state <= S_STBY_OR;
                  else if (cmd_rdata[`DMH_O_NMI_FLAG] || cmd_rdata[`DMH_O_AE])
                     state <= S_IDLE;
                  else
                     state <= S_MON_CH;
               end
            end
            S_STBY_OR: begin
               access(1'b1, DEV_BASE + `DMH_D_OPREG, 32'h0000_0000, DMH_WORD);
               if (cmd_done && waiting)
                  state <= S_STBY_DE;
            end
            S_STBY_DE: begin
               access(1'b1, chan_addr(chan, `DMH_D_CHANNEL_CONTROL_REG), channel_control_reg_img(ctrl, 1'b0), DMH_LONG);
               if (cmd_done && waiting)
                  state <= S_STBY_POLL;
            end
            S_STBY_POLL: begin
               // wait until the channel reads idle
               access(1'b0, chan_addr(chan, `DMH_D_CHANNEL_CONTROL_REG), 32'h0000_0000, DMH_LONG);
               if (cmd_done && waiting)
                  state <= cmd_rdata[`DMH_B_DE] ? S_STBY_POLL : S_IDLE;
            end
            S_NMI_OR: begin
               access(1'b1, DEV_BASE + `DMH_D_OPREG, 32'h0000_0001 << `DMH_O_DME, DMH_WORD);
               if (cmd_done && waiting)
                  state <= S_IDLE;
            end
            default: state <= S_IDLE;
         endcase
      end
   end

   // Outcome flags; a new go clears done, refused and stby_ok, hardware setting wins in the same cycle
   always_ff @(posedge CLOCK or negedge RESET_N) begin
      if (!RESET_N) begin
         done     <= 1'b0;
         refused  <= 1'b0;
         stby_ok  <= 1'b0;
         nmi_seen <= 1'b0;
         ae_seen  <= 1'b0;
      end else begin
         if (state == S_IDLE && pulses[`DMH_C_GO] && !stby_pend && !nmi_pend) begin
            done    <= 1'b0;
            refused <= 1'b0;
            stby_ok <= 1'b0;
         end
         if (state == S_CHECK)
            refused <= (ctrl[`DMH_C_RELOAD] && (!ctrl[`DMH_C_BURST] || count[1:0] != 2'b00)) ||
                       (ctrl[`DMH_C_SINGLE] && src >= INT_BASE) || forbidden(src) || forbidden(dst);
         if (state == S_MON_CH && cmd_done && waiting && cmd_rdata[`DMH_B_TE])
            done <= 1'b1;
         if (state == S_STBY_POLL && cmd_done && waiting && !cmd_rdata[`DMH_B_DE])
            stby_ok <= 1'b1;
         if (state == S_NMI_OR && cmd_done && waiting) begin
            nmi_seen <= 1'b0;
            ae_seen  <= 1'b0;
         end
         if (state == S_MON_OR && cmd_done && waiting) begin
            nmi_seen <= nmi_seen | cmd_rdata[`DMH_O_NMI_FLAG];
            ae_seen  <= ae_seen | cmd_rdata[`DMH_O_AE];
         end
      end
   end

   // Pending software commands; cleared in every serving cycle, so a new pulse beats the clear only in the last one
   always_ff @(posedge CLOCK or negedge RESET_N) begin
      if (!RESET_N) begin
         stby_pend <= 1'b0;
         nmi_pend  <= 1'b0;
      end else begin
         if (state == S_STBY_OR)
            stby_pend <= pulses[`DMH_C_STBY];
         else if (pulses[`DMH_C_STBY])
            stby_pend <= 1'b1;
         if (state == S_NMI_OR)
            nmi_pend <= pulses[`DMH_C_NMICLR];
         else if (pulses[`DMH_C_NMICLR])
            nmi_pend <= 1'b1;
      end
   end

   always_ff @(posedge CLOCK or negedge RESET_N) begin
      if (!RESET_N) begin
         REQ_PIN   <= 1'b1;
         trig_pend <= 1'b0;
         trig_cnt  <= 4'h0;
      end else begin
         if (pulses[`DMH_C_TRIG])
            trig_pend <= 1'b1;
         if (trig_cnt != 4'h0) begin
            trig_cnt <= trig_cnt - 4'h1;
            REQ_PIN  <= (trig_cnt == 4'h1);
         end else if (trig_pend && !programming) begin
            trig_pend <= pulses[`DMH_C_TRIG];
            trig_cnt  <= 4'(`DMH_TRIG_CYC);
            REQ_PIN   <= 1'b0;
         end else begin
            REQ_PIN <= 1'b1;
         end
      end
   end
endmodule // dmh_host

/* File: hw/dmh_pkg.sv */
// Types shared by the DMA host controller modules
package dmh_pkg;
   typedef enum logic {DMH_WORD, DMH_LONG} dmh_size_t;
   typedef enum {
      S_IDLE, S_CHECK, S_RD_CHANNEL_CONTROL_REG, S_CLR_DE, S_WR_TCR0, S_WR_SAR, S_WR_DAR, S_WR_TCR,
      S_WR_OR_ON, S_WR_CHANNEL_CONTROL_REG, S_MON_CH, S_MON_OR, S_STBY_OR, S_STBY_DE, S_STBY_POLL,
      S_NMI_OR
   } dmh_state_t;
endpackage

/* File: hw/dmh_regs.svh */
// Register offsets, field positions and timing counts for the DMA host controller
//
// Summary of operation
// - Reload requires burst bus mode
// - Reload requires count multiple of four
// - Fresh request needed after reload pause
// - Operation register word access only
// - Clear channel enable before changing request select
// - Clear master enable, confirm idle before standby
// - Control register written last when starting
// - Write zero to count before reuse
// - Hold request pin high while programming
// - Single address mode needs external address
// - Never touch unused register addresses
// - Never target controller or bus housekeeping blocks
`ifndef DMH_REGS_SVH
`define DMH_REGS_SVH
// Own APB register map (byte addresses)
`define DMH_A_CTRL      8'h00
`define DMH_A_SRC       8'h04
`define DMH_A_DST       8'h08
`define DMH_A_COUNT     8'h0C
`define DMH_A_STATUS    8'h10
// CTRL fields
`define DMH_C_GO        0
`define DMH_C_STBY      1
`define DMH_C_NMICLR    2
`define DMH_C_TRIG      3
`define DMH_C_RELOAD    4
`define DMH_C_BURST     5
`define DMH_C_IRQEN     6
`define DMH_C_INDIR     7
`define DMH_C_SINGLE    8
`define DMH_C_RS_LO     12
`define DMH_C_SM_LO     16
`define DMH_C_DM_LO     18
`define DMH_C_TS_LO     20
`define DMH_C_CH_LO     22
`define DMH_CTRL_MASK   32'h00FFF1F0
// Device map, relative to the device base
`define DMH_D_SAR       32'h0000_0000
`define DMH_D_DAR       32'h0000_0004
`define DMH_D_TCR       32'h0000_0008
`define DMH_D_CHANNEL_CONTROL_REG      32'h0000_000C
`define DMH_D_STRIDE    32'h0000_0010
`define DMH_D_OPREG     32'h0000_00B0
`define DMH_D_HOLE_LO   32'h0000_00B2
`define DMH_D_HOLE_HI   32'h0000_00BF
`define DMH_D_SPAN      32'h0000_0100
// Device channel control bits
`define DMH_B_DE        0
`define DMH_B_TE        1
`define DMH_B_IE        2
`define DMH_B_TS_LO     3
`define DMH_B_BURST     5
`define DMH_B_INDIR     6
`define DMH_B_SINGLE    7
`define DMH_B_RS_LO     8
`define DMH_B_SM_LO     12
`define DMH_B_DM_LO     14
`define DMH_B_RELOAD    16
// Device operation register bits
`define DMH_O_DME       0
`define DMH_O_NMI_FLAG      1
`define DMH_O_AE        2
`define DMH_TRIG_NS     20
`define DMH_TRIG_CYC    ((`DMH_TRIG_NS + 9) / 10)
`endif
